// ### logic/auxcr_bank.sv
// auxiliary control register bank with pin-clock, beeper and timer prescale
// assumes sfr strobes synchronous to clk_sys and one access per cycle
`timescale 1ns/1ps
`default_nettype none
module auxcr_bank
  import auxcr_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           arst_n,
  input  wire auxcr_sfr_req_s sfr_req,
  output logic [7:0]          sfr_rdata,
  input  wire auxcr_events_s  events,
  input  wire logic           ext_clock_mode,
  input  wire logic           master_clock_tick,
  input  wire logic           low_speed_rc_tick,
  input  wire logic           serial0_pin_select_high,
  input  wire logic           ext_irq1_pin,
  input  wire logic           ext_irq0_pin,
  input  wire logic           timer1_clk_out,
  input  wire logic           timer0_clk_out,
  input  wire logic [5:0]     pwm_out_raw,
  output logic                pin_clock_out,
  output logic                pin_clock_oe,
  output logic                pin_fast_drive,
  output logic                beeper_out,
  output logic                beeper_oe,
  output logic [5:0]          pwm_out,
  output logic                pwm_blocked,
  output logic                ext_irq1_active,
  output logic                ext_irq0_active,
  output logic                timer1_tick,
  output logic                timer0_tick,
  output logic                timer1_clk_pin,
  output logic                timer1_clk_pin_oe,
  output logic                timer0_clk_pin,
  output logic                timer0_clk_pin_oe,
  output auxcr_map_s          pin_map
);
  logic [7:0] pin_clk_q, pin_clk_d;
  logic [7:0] crc_ptr_q, crc_ptr_d;
  logic [7:0] bus_flg_q, bus_flg_d;
  logic [7:0] tmr_bp_q, tmr_bp_d;
  logic [7:0] tmr_cmp_q, tmr_cmp_d;
  logic [7:0] cnt_arr_q, cnt_arr_d;
  logic [1:0] mck_div_q, mck_div_d;
  logic [4:0] beep_div_q, beep_div_d;
  logic [3:0] pre_q, pre_d;
  logic       pin_clk_level_q, pin_clk_level_d;
  logic       beep_level_q, beep_level_d;
  logic       pre_tick;

  function automatic logic hit(input auxcr_sfr_req_s r,
                               input logic [7:0] a);
    hit = r.addr == a;
  endfunction

  function automatic logic hit_page(input auxcr_sfr_req_s r,
                                    input logic [3:0] p);
    hit_page = (r.addr == AUXCR_ADDR_SHARED) && (r.page == p);
  endfunction

  // hardware set beats the software clear in the same cycle
  function automatic logic flag_next(input logic cur, input logic wr,
                                     input logic wbit, input logic set);
    flag_next = set | (wr ? (cur & wbit) : cur);
  endfunction

  // register writes, visible from the next edge
  always_comb begin
    pin_clk_d = pin_clk_q;
    crc_ptr_d = crc_ptr_q;
    bus_flg_d = bus_flg_q;
    tmr_bp_d  = tmr_bp_q;
    tmr_cmp_d = tmr_cmp_q;
    cnt_arr_d = cnt_arr_q;
    if (sfr_req.wr_en) begin
      if (hit(sfr_req, AUXCR_ADDR_PIN_CLK)) begin
        pin_clk_d = sfr_req.wdata;
      end
      if (hit(sfr_req, AUXCR_ADDR_CRC_PTR)) begin
        // reserved bits are dropped even if software breaks the zero rule
        crc_ptr_d = sfr_req.wdata & AUXCR_CRC_PTR_MASK;
      end
      if (hit(sfr_req, AUXCR_ADDR_BUS_FLAGS)) begin
        bus_flg_d[5:0] = sfr_req.wdata[5:0] & AUXCR_BUS_FLAGS_MASK[5:0];
      end
      if (hit_page(sfr_req, AUXCR_PAGE_TMR_BEEP)) begin
        tmr_bp_d = sfr_req.wdata;
      end
      if (hit_page(sfr_req, AUXCR_PAGE_TMR_CMP)) begin
        tmr_cmp_d = sfr_req.wdata;
      end
      if (hit_page(sfr_req, AUXCR_PAGE_CNT_ARR)) begin
        cnt_arr_d = sfr_req.wdata;
      end
    end
    // sticky flags: only a written zero clears them
    pin_clk_d[AUXCR_BIT_BREAK] = flag_next(pin_clk_q[AUXCR_BIT_BREAK],
      sfr_req.wr_en && hit(sfr_req, AUXCR_ADDR_PIN_CLK),
      sfr_req.wdata[AUXCR_BIT_BREAK],
      events.break_src | events.break_sw);
    pin_clk_d[AUXCR_BIT_MOD1] = flag_next(pin_clk_q[AUXCR_BIT_MOD1],
      sfr_req.wr_en && hit(sfr_req, AUXCR_ADDR_PIN_CLK),
      sfr_req.wdata[AUXCR_BIT_MOD1], events.mod1_event);
    pin_clk_d[AUXCR_BIT_MOD0] = flag_next(pin_clk_q[AUXCR_BIT_MOD0],
      sfr_req.wr_en && hit(sfr_req, AUXCR_ADDR_PIN_CLK),
      sfr_req.wdata[AUXCR_BIT_MOD0], events.mod0_event);
    bus_flg_d[AUXCR_BIT_START] = flag_next(bus_flg_q[AUXCR_BIT_START],
      sfr_req.wr_en && hit(sfr_req, AUXCR_ADDR_BUS_FLAGS),
      sfr_req.wdata[AUXCR_BIT_START], events.start_seen);
    bus_flg_d[AUXCR_BIT_STOP] = flag_next(bus_flg_q[AUXCR_BIT_STOP],
      sfr_req.wr_en && hit(sfr_req, AUXCR_ADDR_BUS_FLAGS),
      sfr_req.wdata[AUXCR_BIT_STOP], events.stop_seen);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_clk_q <= AUXCR_RST_VAL;
      crc_ptr_q <= AUXCR_RST_VAL;
      bus_flg_q <= AUXCR_RST_VAL;
      tmr_bp_q  <= AUXCR_RST_VAL;
      tmr_cmp_q <= AUXCR_RST_VAL;
      cnt_arr_q <= AUXCR_RST_VAL;
    end else begin
      pin_clk_q <= pin_clk_d;
      crc_ptr_q <= crc_ptr_d;
      bus_flg_q <= bus_flg_d;
      tmr_bp_q  <= tmr_bp_d;
      tmr_cmp_q <= tmr_cmp_d;
      cnt_arr_q <= cnt_arr_d;
    end
  end

  // read data is registered, one cycle behind rd_en
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    rdata_d = 8'h00;
    if (sfr_req.rd_en) begin
      if (hit(sfr_req, AUXCR_ADDR_PIN_CLK)) begin
        rdata_d = pin_clk_q;
      end else if (hit(sfr_req, AUXCR_ADDR_CRC_PTR)) begin
        rdata_d = crc_ptr_q;
      end else if (hit(sfr_req, AUXCR_ADDR_BUS_FLAGS)) begin
        rdata_d = bus_flg_q;
      end else if (hit_page(sfr_req, AUXCR_PAGE_TMR_BEEP)) begin
        rdata_d = tmr_bp_q;
      end else if (hit_page(sfr_req, AUXCR_PAGE_TMR_CMP)) begin
        rdata_d = tmr_cmp_q;
      end else if (hit_page(sfr_req, AUXCR_PAGE_CNT_ARR)) begin
        rdata_d = cnt_arr_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= AUXCR_RST_VAL;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign sfr_rdata = rdata_q;

  // clock dividers: master clock ticks feed a 2-bit counter, slow rc a 5-bit
  auxcr_pin_fn_e pin_fn;
  auxcr_beep_e   beep_fn;
  assign pin_fn  = auxcr_pin_fn_e'(pin_clk_q[7:6]);
  assign beep_fn = auxcr_beep_e'(tmr_bp_q[5:4]);

  always_comb begin
    mck_div_d       = mck_div_q;
    pin_clk_level_d = pin_clk_level_q;
    if (master_clock_tick) begin
      mck_div_d = mck_div_q + 2'h1;
      case (pin_fn)
        AUXCR_PIN_MCK:      pin_clk_level_d = ~pin_clk_level_q;
        AUXCR_PIN_MCK_DIV2: pin_clk_level_d = mck_div_q[0]
                              ? ~pin_clk_level_q : pin_clk_level_q;
        AUXCR_PIN_MCK_DIV4: pin_clk_level_d = (mck_div_q == 2'h3)
                              ? ~pin_clk_level_q : pin_clk_level_q;
        default:            pin_clk_level_d = 1'b0;
      endcase
    end
  end

  always_comb begin
    beep_div_d   = beep_div_q;
    beep_level_d = beep_level_q;
    if (low_speed_rc_tick) begin
      beep_div_d = beep_div_q + 5'h01;
      // half-period of n/2 ticks gives divide by n
      case (beep_fn)
        AUXCR_BEEP_DIV32: beep_level_d = (beep_div_q[3:0] == 4'hF)
                            ? ~beep_level_q : beep_level_q;
        AUXCR_BEEP_DIV16: beep_level_d = (beep_div_q[2:0] == 3'h7)
                            ? ~beep_level_q : beep_level_q;
        AUXCR_BEEP_DIV8:  beep_level_d = (beep_div_q[1:0] == 2'h3)
                            ? ~beep_level_q : beep_level_q;
        default:          beep_level_d = 1'b0;
      endcase
    end
  end

  // timer prescale: one-cycle enable every twelfth system clock
  always_comb begin
    pre_d = (pre_q == AUXCR_TMR_PRESCALE) ? 4'h0 : pre_q + 4'h1;
  end
  assign pre_tick = pre_q == AUXCR_TMR_PRESCALE;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mck_div_q       <= 2'h0;
      pin_clk_level_q <= 1'b0;
      beep_div_q      <= 5'h00;
      beep_level_q    <= 1'b0;
      pre_q           <= 4'h0;
    end else begin
      mck_div_q       <= mck_div_d;
      pin_clk_level_q <= pin_clk_level_d;
      beep_div_q      <= beep_div_d;
      beep_level_q    <= beep_level_d;
      pre_q           <= pre_d;
    end
  end

  // in external clock mode the pin is an input, field ignored
  assign pin_clock_oe  = !ext_clock_mode
                         && (pin_fn != AUXCR_PIN_GPIO);
  assign pin_clock_out = pin_clk_level_q;
  assign pin_fast_drive = pin_clk_q[AUXCR_BIT_FAST];
  assign beeper_oe  = beep_fn != AUXCR_BEEP_GPIO;
  assign beeper_out = beep_level_q;

  // break holds pwm pins at gpio level (modelled as low) while flagged
  assign pwm_blocked = pin_clk_q[AUXCR_BIT_BREAK];
  assign pwm_out     = pwm_blocked ? 6'h00 : pwm_out_raw;

  // pins are active low by default; polarity bit flips the sense
  assign ext_irq1_active = ext_irq1_pin
                           ~^ pin_clk_q[AUXCR_BIT_IRQ1H];
  assign ext_irq0_active = ext_irq0_pin
                           ~^ pin_clk_q[AUXCR_BIT_IRQ0H];

  assign timer1_tick = bus_flg_q[AUXCR_BIT_T1SPD] | pre_tick;
  assign timer0_tick = bus_flg_q[AUXCR_BIT_T0SPD] | pre_tick;
  assign timer1_clk_pin    = timer1_clk_out;
  assign timer1_clk_pin_oe = bus_flg_q[AUXCR_BIT_TIMER1_CLOCK_OUT_ENABLE];
  assign timer0_clk_pin    = timer0_clk_out;
  assign timer0_clk_pin_oe = bus_flg_q[AUXCR_BIT_TIMER0_CLOCK_OUT_ENABLE];

  always_comb begin
    pin_map.timer0_pin_select     = tmr_bp_q[7:6];
    pin_map.two_wire0_pin_select  = tmr_bp_q[2:1];
    pin_map.serial0_pin_code      = {serial0_pin_select_high,
                                     tmr_bp_q[3]};
    pin_map.serial0_swap          = serial0_pin_select_high
                                    && !tmr_bp_q[3];
    pin_map.crc_port_select       = crc_ptr_q[5:4];
    pin_map.pointer_select        = crc_ptr_q[0];
    pin_map.channel4_input_source = cnt_arr_q[7];
    pin_map.channel2_input_source = cnt_arr_q[6];
    pin_map.timer0_speed_extra    = tmr_bp_q[0];
  end
endmodule
`default_nettype wire

// ### logic/auxcr_pkg.sv
// constants, field layouts and carrier structs of the auxiliary control bank
// assumes an 8-bit special-function-register port driven by the on-chip cpu
// What this block does
// - pin function field: 00 gpio, 01 master clock, 10 clock/2, 11 clock/4
// - any clock option drives the selected master clock division out on the pin
// - external clock input mode reserves the pin; pin function field ignored
// - fast drive bit raises pin drive strength when set
// - break flag set by enabled source or software; blocks pwm channels 0-5
// - break flag is never cleared by hardware, only by software writing zero
// - modulator 1 event flag set by its switch event, cleared by writing zero
// - modulator 0 event flag set by its switch event, cleared by writing zero
// - ext irq 1 polarity bit: set gives high/rising, clear gives low/falling
// - ext irq 0 polarity bit: set gives high/rising, clear gives low/falling
// - pointer select bit: 0 first data pointer, 1 second data pointer
// - crc port select field sits at bits 5 and 4 of second register
// - start detect flag set on bus start, cleared by writing zero
// - stop detect flag set on bus stop, cleared by writing zero
// - timer speed bit: clear counts clock/12, set counts undivided clock
// - timer clock output enable drives the timer clock onto its pin
// - timer 0 pin select field maps timer 0 to one of four pins
// - beeper field: 00 gpio, 01 slow rc/32, 10 /16, 11 /8
// - serial 0 pin code joins bit 3 with external high bit; 10 swaps rx/tx
// - two-wire port 0 pin select maps clock and data to four pin pairs
// - channel input source bit: clear port pin, set timer external input
package auxcr_pkg;
  localparam logic [7:0] AUXCR_ADDR_PIN_CLK   = 8'hA1;
  localparam logic [7:0] AUXCR_ADDR_CRC_PTR   = 8'hA2;
  localparam logic [7:0] AUXCR_ADDR_SHARED    = 8'hA4;
  // no printed address for the bus-flag register; chosen free slot
  localparam logic [7:0] AUXCR_ADDR_BUS_FLAGS = 8'hA3;
  localparam logic [3:0] AUXCR_PAGE_TMR_BEEP  = 4'h0;
  localparam logic [3:0] AUXCR_PAGE_TMR_CMP   = 4'h1;
  localparam logic [3:0] AUXCR_PAGE_CNT_ARR   = 4'h2;
  localparam logic [7:0] AUXCR_RST_VAL        = 8'h00;
  localparam logic [7:0] AUXCR_CRC_PTR_MASK   = 8'h31;
  localparam logic [7:0] AUXCR_BUS_FLAGS_MASK = 8'hCF;
  localparam int AUXCR_BIT_FAST   = 5;
  localparam int AUXCR_BIT_BREAK  = 4;
  localparam int AUXCR_BIT_MOD1   = 3;
  localparam int AUXCR_BIT_MOD0   = 2;
  localparam int AUXCR_BIT_IRQ1H  = 1;
  localparam int AUXCR_BIT_IRQ0H  = 0;
  localparam int AUXCR_BIT_START  = 7;
  localparam int AUXCR_BIT_STOP   = 6;
  localparam int AUXCR_BIT_T1SPD  = 3;
  localparam int AUXCR_BIT_T0SPD  = 2;
  localparam int AUXCR_BIT_TIMER1_CLOCK_OUT_ENABLE = 1;
  localparam int AUXCR_BIT_TIMER0_CLOCK_OUT_ENABLE = 0;
  localparam logic [3:0] AUXCR_TMR_PRESCALE = 4'hB;
  localparam logic [4:0] AUXCR_BEEP_DIV_MAX = 5'h1F;

  typedef enum logic [1:0] {
    AUXCR_PIN_GPIO,
    AUXCR_PIN_MCK,
    AUXCR_PIN_MCK_DIV2,
    AUXCR_PIN_MCK_DIV4
  } auxcr_pin_fn_e;

  typedef enum logic [1:0] {
    AUXCR_BEEP_GPIO,
    AUXCR_BEEP_DIV32,
    AUXCR_BEEP_DIV16,
    AUXCR_BEEP_DIV8
  } auxcr_beep_e;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [3:0] page;
    logic [7:0] wdata;
  } auxcr_sfr_req_s;

  typedef struct packed {
    logic break_src;
    logic break_sw;
    logic mod1_event;
    logic mod0_event;
    logic start_seen;
    logic stop_seen;
  } auxcr_events_s;

  typedef struct packed {
    logic [1:0] timer0_pin_select;
    logic [1:0] two_wire0_pin_select;
    logic [1:0] serial0_pin_code;
    logic       serial0_swap;
    logic [1:0] crc_port_select;
    logic       pointer_select;
    logic       channel4_input_source;
    logic       channel2_input_source;
    logic       timer0_speed_extra;
  } auxcr_map_s;
endpackage

// ### bench/auxcr_bank_monitor.sv
// assertion checker for the auxiliary control bank, bound to its ports
// assumes one clk_sys domain with asynchronous active-low arst_n
`timescale 1ns/1ps
`default_nettype none
module auxcr_bank_monitor
  import auxcr_pkg::*;
(
  input wire logic           clk_sys,
  input wire logic           arst_n,
  input wire auxcr_sfr_req_s sfr_req,
  input wire auxcr_events_s  events,
  input wire logic           ext_clock_mode,
  input wire logic           ext_irq1_pin,
  input wire logic           ext_irq0_pin,
  input wire logic           timer0_clk_out,
  input wire logic [5:0]     pwm_out_raw,
  input wire logic           pin_clock_oe,
  input wire logic           pin_fast_drive,
  input wire logic [5:0]     pwm_out,
  input wire logic           pwm_blocked,
  input wire logic           ext_irq1_active,
  input wire logic           ext_irq0_active,
  input wire logic           timer0_clk_pin,
  input wire logic           timer0_clk_pin_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic wr_a1;
  logic brk_clr;
  assign wr_a1 = sfr_req.wr_en && sfr_req.addr == AUXCR_ADDR_PIN_CLK;
  // a clear that meets a new break event must lose, so events are excluded
  assign brk_clr = wr_a1 && !sfr_req.wdata[AUXCR_BIT_BREAK];
  property p_pwm_block; pwm_blocked |-> pwm_out == 6'h00; endproperty
  a_pwm_block: assert property (p_pwm_block)
    else $error("pwm driven during break");
  property p_pwm_pass; !pwm_blocked |-> pwm_out == pwm_out_raw; endproperty
  a_pwm_pass: assert property (p_pwm_pass)
    else $error("pwm not passed through");
  property p_brk_set; events.break_src || events.break_sw |=> pwm_blocked;
  endproperty
  a_brk_set: assert property (p_brk_set)
    else $error("break event not latched");
  property p_brk_hold; pwm_blocked && !brk_clr |=> pwm_blocked; endproperty
  a_brk_hold: assert property (p_brk_hold)
    else $error("break flag dropped without software");
  property p_brk_clr;
    brk_clr && !events.break_src && !events.break_sw |=> !pwm_blocked;
  endproperty
  a_brk_clr: assert property (p_brk_clr)
    else $error("break flag not cleared by write");
  property p_fast; wr_a1 |=> pin_fast_drive == $past(sfr_req.wdata[5]);
  endproperty
  a_fast: assert property (p_fast)
    else $error("fast drive not updated");
  property p_irq1; $past(ext_irq1_pin) != ext_irq1_pin && !$past(wr_a1)
    |-> $past(ext_irq1_active) != ext_irq1_active; endproperty
  a_irq1: assert property (p_irq1)
    else $error("irq1 active ignores pin");
  property p_irq0; $past(ext_irq0_pin) != ext_irq0_pin && !$past(wr_a1)
    |-> $past(ext_irq0_active) != ext_irq0_active; endproperty
  a_irq0: assert property (p_irq0)
    else $error("irq0 active ignores pin");
  property p_ext_clk; ext_clock_mode |-> !pin_clock_oe; endproperty
  a_ext_clk: assert property (p_ext_clk)
    else $error("pin driven in external clock mode");
  property p_t0pin; timer0_clk_pin_oe |-> timer0_clk_pin == timer0_clk_out;
  endproperty
  a_t0pin: assert property (p_t0pin)
    else $error("timer0 clock pin wrong");
endmodule
bind auxcr_bank auxcr_bank_monitor u_mon (
  .clk_sys(clk_sys), .arst_n(arst_n), .sfr_req(sfr_req), .events(events),
  .ext_clock_mode(ext_clock_mode), .ext_irq1_pin(ext_irq1_pin),
  .ext_irq0_pin(ext_irq0_pin), .timer0_clk_out(timer0_clk_out),
  .pwm_out_raw(pwm_out_raw), .pin_clock_oe(pin_clock_oe),
  .pin_fast_drive(pin_fast_drive), .pwm_out(pwm_out),
  .pwm_blocked(pwm_blocked), .ext_irq1_active(ext_irq1_active),
  .ext_irq0_active(ext_irq0_active), .timer0_clk_pin(timer0_clk_pin),
  .timer0_clk_pin_oe(timer0_clk_pin_oe));
`default_nettype wire

// ### bench/auxcr_bank_test.sv
// self-checking bench for the auxiliary control register bank
// assumes the bank alone, driven through its sfr strobes at 40 MHz
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module auxcr_bank_test
  import auxcr_pkg::*;
;
  logic           clk_sys = 1'b0;
  logic           arst_n, ecm, mtick, stick, s0h, irq1, irq0, t1o, t0o;
  logic           pco, pcoe, pfd, bo, boe, pblk, ia1, ia0, tk1, tk0;
  logic           tp1, tp1oe, tp0, tp0oe, lp, lb;
  logic [5:0]     raw, pwm;
  logic [7:0]     rdata, q, w, a;
  auxcr_sfr_req_s req;
  auxcr_events_s  ev;
  auxcr_map_s     pm;
  int             fails = 0, compares = 0, pc, bc, c0, c1, i;
  logic [7:0]     ta [8] = '{8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA4, 8'hA4,
                             8'hA4, 8'h55};
  logic [3:0]     tp [8] = '{0, 0, 0, 0, 1, 2, 3, 0};
  int             fb [6] = '{4, 4, 3, 2, 7, 6};
  auxcr_bank dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .sfr_req(req), .sfr_rdata(rdata),
    .events(ev), .ext_clock_mode(ecm), .master_clock_tick(mtick),
    .low_speed_rc_tick(stick), .serial0_pin_select_high(s0h),
    .ext_irq1_pin(irq1), .ext_irq0_pin(irq0), .timer1_clk_out(t1o),
    .timer0_clk_out(t0o), .pwm_out_raw(raw), .pin_clock_out(pco),
    .pin_clock_oe(pcoe), .pin_fast_drive(pfd), .beeper_out(bo),
    .beeper_oe(boe), .pwm_out(pwm), .pwm_blocked(pblk),
    .ext_irq1_active(ia1), .ext_irq0_active(ia0), .timer1_tick(tk1),
    .timer0_tick(tk0), .timer1_clk_pin(tp1), .timer1_clk_pin_oe(tp1oe),
    .timer0_clk_pin(tp0), .timer0_clk_pin_oe(tp0oe), .pin_map(pm));
  always #12.5 clk_sys = ~clk_sys;
  // counting on the falling edge keeps clear of the launch edge updates
  always @(negedge clk_sys) begin
    pc += (pco !== lp);
    bc += (bo !== lb);
    lp = pco;
    lb = bo;
    c0 += tk0;
    c1 += tk1;
  end
  function int pexp(input int m);
    return m == 0 ? 0 : 64 >> (m - 1);
  endfunction
  function int bexp(input int m);
    return m == 0 ? 0 : 4 << (m - 1);
  endfunction
  task stir;
    {irq1, irq0, t1o, t0o, raw} = 10'($urandom);
  endtask
  task zc;
    pc = 0;
    bc = 0;
    c0 = 0;
    c1 = 0;
  endtask
  // one access, then a spare edge so strobes never change twice at once
  task acc(input logic wr, input logic [7:0] ad, input logic [3:0] p,
           input logic [7:0] d);
    req = '{wr, !wr, ad, p, d};
    @(posedge clk_sys);
    #2 req = '0;
    q = rdata;
    @(posedge clk_sys);
    #2;
  endtask
  task results;
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {req, ev, ecm, mtick, stick, s0h, irq1, irq0, t1o, t0o} = '0;
    {raw, arst_n, lp, lb} = '0;
    i = $urandom(32'h3ddc_8866);
    repeat (8) @(posedge clk_sys);
    #2 arst_n = 1'b1;
    acc(1, 8'hA4, 4'h3, 8'hFF);
    acc(1, 8'h55, 4'h0, 8'hFF);
    for (i = 0; i < 8; i++) begin
      acc(0, ta[i], tp[i], 8'h00);
      `CHK("reset read", 8'h00, q)
    end
    for (i = 0; i < 20; i++) begin
      w = 8'($urandom);
      ecm = 1'($urandom);
      stir;
      acc(1, 8'hA1, 4'($urandom), w);
      `CHK("fast drive", w[5], pfd)
      `CHK("irq0 active", irq0 ~^ w[0], ia0)
      `CHK("irq1 active", irq1 ~^ w[1], ia1)
      `CHK("pin oe", !ecm && w[7:6] != 2'b00, pcoe)
      acc(0, 8'hA1, 4'h0, 8'h00);
      `CHK("aux0 read", w & 8'hE3, q)
    end
    acc(1, 8'hA1, 4'h0, 8'h00);
    for (i = 0; i < 6; i++) begin
      a = i < 4 ? 8'hA1 : 8'hA3;
      stir;
      ev = 6'(6'h20 >> i);
      @(posedge clk_sys);
      #2 ev = '0;
      repeat (5) @(posedge clk_sys);
      #2 acc(1, a, 4'h0, 8'(8'h01 << fb[i]));
      acc(0, a, 4'h0, 8'h00);
      `CHK("flag set", 8'(8'h01 << fb[i]), q)
      `CHK("blocked", i < 2, pblk)
      `CHK("pwm out", i < 2 ? 6'h00 : raw, pwm)
      acc(1, a, 4'h0, 8'h00);
      acc(0, a, 4'h0, 8'h00);
      `CHK("flag clear", 8'h00, q)
      // event and clearing write on one edge: the event must win
      req = '{1'b1, 1'b0, a, 4'h0, 8'h00};
      ev = 6'(6'h20 >> i);
      @(posedge clk_sys);
      #2 {req, ev} = '0;
      acc(0, a, 4'h0, 8'h00);
      `CHK("set wins", 8'(8'h01 << fb[i]), q)
      acc(1, a, 4'h0, 8'h00);
    end
    for (i = 0; i < 4; i++) begin
      w = 8'hF0 | {4'h0, i[1:0], ~i[1:0]};
      stir;
      acc(1, 8'hA3, 4'h0, w);
      zc;
      repeat (48) @(posedge clk_sys);
      #2;
      `CHK("t1 ticks", w[3] ? 48 : 4, c1)
      `CHK("t0 ticks", w[2] ? 48 : 4, c0)
      `CHK("t1 oe", w[1], tp1oe)
      `CHK("t0 oe", w[0], tp0oe)
      `CHK("t1 pin", t1o, tp1)
      acc(0, 8'hA3, 4'h0, 8'h00);
      `CHK("aux2 read", w & 8'h0F, q)
    end
    ecm = 1'b0;
    mtick = 1'b1;
    stick = 1'b1;
    for (i = 0; i < 4; i++) begin
      acc(1, 8'hA1, 4'h0, {i[1:0], 6'h00});
      acc(1, 8'hA4, 4'h0, {2'b00, i[1:0], 4'h0});
      zc;
      repeat (64) @(posedge clk_sys);
      #2;
      `CHK("pin clock", 1'b1, pc >= pexp(i) - 1 && pc <= pexp(i))
      `CHK("beeper", 1'b1, bc >= bexp(i) - 1 && bc <= bexp(i))
      `CHK("beeper oe", i != 0, boe)
    end
    for (i = 0; i < 12; i++) begin
      w = 8'($urandom);
      s0h = 1'($urandom);
      stir;
      acc(1, 8'hA4, 4'h0, w);
      `CHK("t0 pins", w[7:6], pm.timer0_pin_select)
      `CHK("twi pins", w[2:1], pm.two_wire0_pin_select)
      `CHK("s0 code", {s0h, w[3]}, pm.serial0_pin_code)
      `CHK("s0 swap", {s0h, w[3]} == 2'b10, pm.serial0_swap)
      `CHK("t0 extra", w[0], pm.timer0_speed_extra)
      acc(1, 8'hA2, 4'h0, w & 8'h31);
      `CHK("crc port", w[5:4], pm.crc_port_select)
      `CHK("pointer", w[0], pm.pointer_select)
      acc(1, 8'hA4, 4'h2, w);
      `CHK("ch4 src", w[7], pm.channel4_input_source)
      `CHK("ch2 src", w[6], pm.channel2_input_source)
      acc(1, 8'hA4, 4'h1, ~w);
      acc(0, 8'hA4, 4'h1, 8'h00);
      `CHK("aux4 read", ~w, q)
      acc(0, 8'hA4, 4'h0, 8'h00);
      `CHK("aux3 read", w, q)
    end
    // reserved bits are forced low even when software breaks the write rule
    acc(1, 8'hA2, 4'h0, 8'hFF);
    acc(0, 8'hA2, 4'h0, 8'h00);
    `CHK("aux1 read", 8'h31, q)
    results;
  end
endmodule
`default_nettype wire
